// [design/lcr_pkg.sv]
// Constants and types for the clock request sideband controller.
// Operation
// [R01] Pull request line low whenever the reference clock is needed.
// [R02] Power management off: request always asserted, except in L1 substates; the code also releases it in L2 or L3.
// [R03] Power management on: request may be released in L1.
// [R04] In L1 substates either party may pull the line to exit.
// [R05] Keep working when the clock keeps running after release.
// [R06] Request asserted at power-up, in any reset, and when needed.
// [R07] Fundamental reset asserted keeps the request asserted.
// [R08] Release only once truly ready for the clock to park.
// [R09] Receive idle exit asserts the request, clock running or parked.
// [R10] Request logic runs on a clock other than the reference.
// [R11] Release at once on L1 entry; parking may follow immediately.
// [R12] After asserting, tolerate the clock parked up to 400 ns.
// [R13] Host may delay the clock longer under latency tolerance.
// [R14] Reported L1 exit latency includes request and restore time.
// [R15] Release only after all links reached L1 idle.
// [R16] Assert together with leaving transmit electrical idle.
// [R17] Release the request in L2 or L3 as in L1.
// [R18] Capability bit 18 at offset 0ch reports request support.
// [R19] Enable bit 8 at offset 10h, set at power-up and warm reset.
// [R20] Host drives fundamental reset around power changes.
// [R21] Fundamental reset release initialises the card functions.
// [R22] Wake output is built when wake or flush hints are supported.
// [R23] Host runs the clock 100 us before releasing reset.
// [R24] Detect within 20 ms and configuration ready within 120 ms.
// [R25] Reset and sensed request pass two synchroniser stages.
// [R26] Request pad is only pulled low, never driven high.
package lcr_pkg;
    localparam int unsigned CLK_MHZ              = 200;
    localparam int unsigned CLK_PERIOD_PS        = 5000;
    localparam int unsigned ASSERT_TO_ACTIVE_NS  = 400;
    localparam int unsigned ASSERT_TO_ACTIVE_CYC =
        (ASSERT_TO_ACTIVE_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned CLK_IDLE_NS          = 160;
    localparam int unsigned CLK_IDLE_CYC         =
        (CLK_IDLE_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned CFG_MAX_MS           = 120;
    localparam int unsigned CFG_MAX_CYC          = CFG_MAX_MS * 1000 * CLK_MHZ;
    localparam logic [2:0]  SENSE_BLANK_CYC      = 3'h4;
    localparam int unsigned ADDR_W               = 8;
    localparam logic [7:0]  OFS_FEATURE          = 8'h0c;
    localparam logic [7:0]  OFS_CONTROL          = 8'h10;
    localparam logic [7:0]  OFS_STATUS           = 8'h14;
    localparam logic [7:0]  OFS_WAKE             = 8'h18;
    localparam logic [7:0]  OFS_EXIT_LAT         = 8'h1c;
    localparam int unsigned BIT_REQ_SUPPORT      = 18;
    localparam int unsigned BIT_PM_EN            = 8;
    localparam logic        PM_EN_RST            = 1'h1;
    localparam int unsigned ST_REQ               = 0;
    localparam int unsigned ST_CLK_ACT           = 1;
    localparam int unsigned ST_PARKED            = 2;
    localparam int unsigned ST_LATE              = 3;
    localparam int unsigned ST_RST_REL           = 4;
    localparam int unsigned ST_CFG_RDY           = 5;
    localparam int unsigned WK_PEND              = 0;
    localparam int unsigned WK_FLUSH             = 1;

    typedef enum logic [1:0] {
        LCR_RESET  = 2'b00,
        LCR_ACTIVE = 2'b01,
        LCR_PARKED = 2'b10,
        LCR_EXIT   = 2'b11
    } lcr_fsm_t;
endpackage

// [design/lcr_clock_request.sv]
// Clock request sideband controller with register port and wake output.
`timescale 1ns/1ps
`default_nettype none
module lcr_clock_request #(
    parameter int unsigned CFG_READY_CYC   = lcr_pkg::CFG_MAX_CYC,
    parameter bit          REQ_SUPPORT     = 1'b1,
    parameter bit          WAKE_SUPPORT    = 1'b1,
    parameter bit          FLUSH_SUPPORT   = 1'b1,
    parameter int unsigned L1_EXIT_BASE_NS = 1000
) (
    // Clock and reset.
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    // Pins from the host.
    input  wire logic        fundamental_reset_n_in,
    input  wire logic        ref_clock_in,
    // Shared open-drain request line.
    input  wire logic        clock_request_n_in,
    output logic             clock_request_n_out,
    output logic             clock_request_oe_n_out,
    // Shared open-drain wake line.
    input  wire logic        wake_request_n_in,
    output logic             wake_request_n_out,
    output logic             wake_request_oe_n_out,
    // Link state from the local link logic.
    input  wire logic        link_l1_idle_in,
    input  wire logic        l1_substate_in,
    input  wire logic        link_l23_in,
    input  wire logic        link_need_clk_in,
    input  wire logic        rx_idle_exit_in,
    input  wire logic        tx_idle_exit_in,
    input  wire logic        wake_event_in,
    // Indications to the card.
    output logic             l1_exit_request_out,
    output logic             card_reset_n_out,
    output logic             train_enable_out,
    output logic             config_ready_out,
    output logic             flush_hint_out,
    // Register port.
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_en_in,
    input  wire logic        rd_en_in,
    output logic [31:0]      rdata_out
);
    localparam int unsigned CW = $clog2(CFG_READY_CYC + 1);
    localparam int A_LAST = lcr_pkg::ASSERT_TO_ACTIVE_CYC - 1;

    typedef struct packed {
        lcr_pkg::lcr_fsm_t fsm;
        logic              cr_oe_n;
        logic              pm_en;
        logic [6:0]        exit_cnt;
        logic [2:0]        blank;
        logic              late;
        logic              rst_s1;
        logic              rst_s2;
        logic              sense_s1;
        logic              sense_s2;
        logic              ref_s1;
        logic              ref_s2;
        logic              ref_s3;
        logic [5:0]        idle_cnt;
        logic              clk_act;
        logic              wk_s1;
        logic              wk_s2;
        logic              wk_oe_n;
        logic [1:0]        wk_rel;
        logic              flush;
        logic              card_rst_n;
        logic              train_en;
        logic [CW-1:0]     cfg_cnt;
        logic              cfg_rdy;
        logic              l1_exit;
        logic              pad_low;
        logic [31:0]       rdata;
    } lcr_regs_t;

    // The request is driven from the moment the asynchronous reset asserts, with no clock edge needed.
    localparam lcr_regs_t RST_VAL = '{
        fsm:      lcr_pkg::LCR_RESET,
        cr_oe_n:  1'h0,
        pm_en:    lcr_pkg::PM_EN_RST,
        wk_oe_n:  1'h1,
        // Wake sense copies start at the idle level, so no false hint follows reset.
        wk_s1:    1'h1,
        wk_s2:    1'h1,
        wk_rel:   2'h3,
        card_rst_n: 1'h0,
        default:  '0
    };

    lcr_regs_t q;
    lcr_regs_t d;

    logic rst_on;
    logic wake_link;
    logic park_ok;
    logic host_req;
    logic wr_ctl;
    logic wr_st;
    logic wr_wk;

    always_comb begin
        d = q;
        // Pins cross into the local domain through two stages.
        d.rst_s1   = fundamental_reset_n_in; // [R25]
        d.rst_s2   = q.rst_s1;
        d.sense_s1 = clock_request_n_in; // [R25]
        d.sense_s2 = q.sense_s1;
        d.ref_s1   = ref_clock_in; // [R10]
        d.ref_s2   = q.ref_s1;
        d.ref_s3   = q.ref_s2;
        d.wk_s1    = wake_request_n_in;
        d.wk_s2    = q.wk_s1;
        d.pad_low  = 1'h0; // [R26]
        d.rdata    = '0;

        rst_on    = ~q.rst_s2;
        wake_link = rx_idle_exit_in | tx_idle_exit_in | link_need_clk_in;
        // Substates allow a release even with power management off.
        park_ok   = link_l23_in // [R17]
                  | (link_l1_idle_in & (q.pm_en | l1_substate_in)); // [R02] [R03] [R15]
        // Our own release takes a few cycles to reach the sensed copy.
        host_req  = ~q.sense_s2 & (q.blank == 3'h0);
        wr_ctl    = wr_en_in & (addr_in == lcr_pkg::OFS_CONTROL);
        wr_st     = wr_en_in & (addr_in == lcr_pkg::OFS_STATUS);
        wr_wk     = wr_en_in & (addr_in == lcr_pkg::OFS_WAKE);

        // Reference clock activity, seen only through its sampled edges.
        if (q.ref_s2 != q.ref_s3) begin
            d.idle_cnt = '0;
            d.clk_act  = 1'h1;
        end else if (q.idle_cnt == 6'(lcr_pkg::CLK_IDLE_CYC - 1)) begin
            d.clk_act = 1'h0;
        end else begin
            d.idle_cnt = q.idle_cnt + 6'h1;
        end

        // Card functions follow the synchronised reset.
        d.card_rst_n = q.rst_s2; // [R21]
        d.train_en   = q.card_rst_n; // [R24]
        if (rst_on) begin
            d.cfg_cnt = '0;
            d.cfg_rdy = 1'h0;
        end else if (!q.cfg_rdy) begin
            if (q.cfg_cnt == CW'(CFG_READY_CYC - 1)) begin
                d.cfg_rdy = 1'h1; // [R24]
            end else begin
                d.cfg_cnt = q.cfg_cnt + CW'(1);
            end
        end

        // Dynamic clock enable, set again by every warm reset.
        if (wr_ctl) begin
            d.pm_en = wdata_in[lcr_pkg::BIT_PM_EN];
        end
        if (rst_on) begin
            d.pm_en = lcr_pkg::PM_EN_RST; // [R19]
        end

        // Wake request; a new event beats a clear in the same cycle.
        if ((wr_wk && wdata_in[lcr_pkg::WK_PEND]) || (q.rst_s2 && !q.card_rst_n)) begin
            d.wk_oe_n = 1'h1;
        end
        if (wake_event_in && WAKE_SUPPORT) begin
            d.wk_oe_n = 1'h0; // [R22]
        end
        // Our own release takes two sense stages to show, so hold the hint off until then.
        d.wk_rel = {q.wk_rel[0], q.wk_oe_n};
        d.flush  = FLUSH_SUPPORT & q.wk_oe_n & (&q.wk_rel) & ~q.wk_s2; // [R22]

        if (wr_st && wdata_in[lcr_pkg::ST_LATE]) begin
            d.late = 1'h0;
        end
        if (q.blank != 3'h0) begin
            d.blank = q.blank - 3'h1;
        end

        unique case (q.fsm)
            lcr_pkg::LCR_RESET: begin
                d.cr_oe_n = 1'h0; // [R06]
                d.fsm     = lcr_pkg::LCR_ACTIVE;
            end
            lcr_pkg::LCR_ACTIVE: begin
                d.cr_oe_n = 1'h0; // [R01]
                // Release at once; the clock may park with no delay.
                if (park_ok && !wake_link) begin
                    d.cr_oe_n = 1'h1; // [R08] [R11]
                    d.blank   = lcr_pkg::SENSE_BLANK_CYC;
                    d.fsm     = lcr_pkg::LCR_PARKED;
                end
            end
            lcr_pkg::LCR_PARKED: begin
                d.cr_oe_n = 1'h1; // [R05]
                if (wake_link || host_req || !park_ok) begin
                    d.cr_oe_n  = 1'h0; // [R09] [R16] [R04]
                    d.exit_cnt = '0;
                    d.l1_exit  = 1'h1;
                    d.fsm      = lcr_pkg::LCR_EXIT;
                end
            end
            lcr_pkg::LCR_EXIT: begin
                d.cr_oe_n = 1'h0; // [R12]
                if (q.exit_cnt != 7'(A_LAST + 1)) begin
                    d.exit_cnt = q.exit_cnt + 7'h1;
                end
                // Late is only a status; the host may delay under tolerance.
                if (q.exit_cnt == 7'(A_LAST) && !q.clk_act) begin
                    d.late = 1'h1; // [R13]
                end
                if (q.clk_act && !link_l1_idle_in && !link_l23_in) begin
                    d.l1_exit = 1'h0;
                    d.fsm     = lcr_pkg::LCR_ACTIVE;
                end
            end
        endcase

        if (rst_on) begin
            d.cr_oe_n = 1'h0; // [R07]
            d.l1_exit = 1'h0;
            d.fsm     = lcr_pkg::LCR_RESET;
        end

        if (rd_en_in) begin
            unique case (addr_in)
                lcr_pkg::OFS_FEATURE: begin
                    d.rdata[lcr_pkg::BIT_REQ_SUPPORT] = REQ_SUPPORT; // [R18]
                end
                lcr_pkg::OFS_CONTROL: begin
                    d.rdata[lcr_pkg::BIT_PM_EN] = q.pm_en;
                end
                lcr_pkg::OFS_STATUS: begin
                    d.rdata[lcr_pkg::ST_REQ]     = ~q.cr_oe_n;
                    d.rdata[lcr_pkg::ST_CLK_ACT] = q.clk_act;
                    d.rdata[lcr_pkg::ST_PARKED]  = q.fsm == lcr_pkg::LCR_PARKED;
                    d.rdata[lcr_pkg::ST_LATE]    = q.late;
                    d.rdata[lcr_pkg::ST_RST_REL] = q.card_rst_n;
                    d.rdata[lcr_pkg::ST_CFG_RDY] = q.cfg_rdy;
                end
                lcr_pkg::OFS_WAKE: begin
                    d.rdata[lcr_pkg::WK_PEND]  = ~q.wk_oe_n;
                    d.rdata[lcr_pkg::WK_FLUSH] = q.flush;
                end
                lcr_pkg::OFS_EXIT_LAT: begin
                    d.rdata = 32'(L1_EXIT_BASE_NS + lcr_pkg::ASSERT_TO_ACTIVE_NS); // [R14]
                end
                default: begin
                    d.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            q <= RST_VAL;
        end else begin
            q <= d;
        end
    end

    assign clock_request_n_out    = q.pad_low;
    assign clock_request_oe_n_out = q.cr_oe_n;
    assign wake_request_n_out     = q.pad_low;
    assign wake_request_oe_n_out  = q.wk_oe_n;
    assign l1_exit_request_out    = q.l1_exit;
    assign card_reset_n_out       = q.card_rst_n;
    assign train_enable_out       = q.train_en;
    assign config_ready_out       = q.cfg_rdy;
    assign flush_hint_out         = q.flush;
    assign rdata_out              = q.rdata;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    sequence s_parked_settled;
        q.fsm == lcr_pkg::LCR_PARKED && q.blank == 3'h0;
    endsequence

    sequence s_host_pull;
        !q.sense_s2;
    endsequence

    sequence s_exit_timeout;
        q.fsm == lcr_pkg::LCR_EXIT && q.exit_cnt == 7'(A_LAST) && !q.clk_act;
    endsequence

    property p_reset_holds;
        !q.rst_s2 |=> !clock_request_oe_n_out && !l1_exit_request_out;
    endproperty
    a_reset_holds: assert property (p_reset_holds) // [R07]
        else $error("request released during fundamental reset");

    property p_release_enabled;
        $rose(clock_request_oe_n_out)
            |-> $past(q.pm_en || l1_substate_in || link_l23_in);
    endproperty
    a_release_enabled: assert property (p_release_enabled) // [R02]
        else $error("request released with clock management off");

    property p_release_idle;
        $rose(clock_request_oe_n_out)
            |-> $past(link_l1_idle_in || link_l23_in) && $past(q.rst_s2);
    endproperty
    a_release_idle: assert property (p_release_idle) // [R15]
        else $error("request released before links were idle");

    property p_tx_exit;
        q.fsm == lcr_pkg::LCR_PARKED && tx_idle_exit_in && q.rst_s2
            |=> !clock_request_oe_n_out ##0 l1_exit_request_out;
    endproperty
    a_tx_exit: assert property (p_tx_exit) // [R16]
        else $error("transmit idle exit did not assert request");

    property p_rx_exit;
        q.fsm == lcr_pkg::LCR_PARKED && rx_idle_exit_in && q.rst_s2
            |=> !clock_request_oe_n_out;
    endproperty
    a_rx_exit: assert property (p_rx_exit) // [R09]
        else $error("receive idle exit did not assert request");

    property p_host_exit;
        s_parked_settled ##0 s_host_pull ##0 q.rst_s2
            |=> !clock_request_oe_n_out && l1_exit_request_out;
    endproperty
    a_host_exit: assert property (p_host_exit) // [R04]
        else $error("host pull did not start an exit");

    property p_late_flag;
        s_exit_timeout ##0 q.rst_s2 |=> q.late [*2];
    endproperty
    a_late_flag: assert property (p_late_flag) // [R12]
        else $error("parked clock past limit not flagged");

    property p_enable_default;
        !q.rst_s2 ##1 q.rst_s2 |-> q.pm_en;
    endproperty
    a_enable_default: assert property (p_enable_default) // [R19]
        else $error("clock management not enabled after reset");

    property p_card_init;
        $rose(q.rst_s2) |=> card_reset_n_out ##1 train_enable_out;
    endproperty
    a_card_init: assert property (p_card_init) // [R21]
        else $error("card release did not follow fundamental reset");

    property p_clock_back;
        q.fsm == lcr_pkg::LCR_EXIT && q.clk_act && q.rst_s2
            && !link_l1_idle_in && !link_l23_in
            |=> q.fsm == lcr_pkg::LCR_ACTIVE && !clock_request_oe_n_out;
    endproperty
    a_clock_back: assert property (p_clock_back) // [R05]
        else $error("active clock did not end the exit");

    property p_cfg_ready;
        $rose(config_ready_out) |-> $past(q.cfg_cnt) == CW'(CFG_READY_CYC - 1);
    endproperty
    a_cfg_ready: assert property (p_cfg_ready) // [R24]
        else $error("configuration ready at wrong count");

    property p_open_drain;
        clock_request_n_out == 1'b0 && wake_request_n_out == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) // [R26]
        else $error("pad driven high");

    property p_wake;
        wake_event_in |=> !wake_request_oe_n_out;
    endproperty
    a_wake: assert property (p_wake) // [R22]
        else $error("wake event did not pull the wake line");
endmodule
`default_nettype wire

// [test/lcr_host_model.sv]
// Host side model: reference clock generator, request wire and reset control.
`timescale 1ns/1ps
`default_nettype none
module lcr_host_model #(
    parameter int unsigned RST_WAIT_NS = 100000
) (
    // Device side of the shared request wire.
    input  wire logic req_oe_n_in,
    // Host behaviour commands.
    input  wire logic host_pull_in,
    input  wire logic slow_in,
    input  wire logic power_ok_in,
    // Lines to the device.
    output logic      ref_clock_out,
    output logic      wire_n_out,
    output logic      fund_rst_n_out
);
    logic run = 1'b0;

    // The pull-up wins unless either party pulls the wire low.
    assign wire_n_out = req_oe_n_in & ~host_pull_in;

    // A parked clock is held at ground by the termination.
    initial begin
        ref_clock_out = 1'b0;
        forever begin
            #32;
            ref_clock_out = run & ~ref_clock_out;
        end
    end

    // Parking lags the release, so the device must cope with a running clock.
    // Level waits, so a change during a delay is never lost.
    always begin
        wait (wire_n_out === 1'b0);
        #(slow_in ? 900 : 120);
        if (wire_n_out === 1'b0) run = 1'b1;
        wait (wire_n_out === 1'b1);
        #200;
        if (wire_n_out === 1'b1) run = 1'b0;
    end

    initial begin
        fund_rst_n_out = 1'b0;
        forever begin
            @(posedge power_ok_in);
            wait (run);
            #(RST_WAIT_NS);
            fund_rst_n_out = power_ok_in;
            @(negedge power_ok_in);
            fund_rst_n_out = 1'b0;
        end
    end
endmodule
`default_nettype wire

// [test/lcr_clock_request_tb.sv]
// Self-checking bench for the clock request sideband controller.
`timescale 1ns/1ps
`default_nettype none
module lcr_clock_request_tb;
    localparam int unsigned EXIT_BASE = 1000;
    localparam int O_REQ = 0, O_EXIT = 1, O_CRST = 2, O_CFG = 3, O_WAKE = 4, O_FLUSH = 5;

    logic        clk_in, arst_n, l1_idle, subst, l23, need_clk, rx_exit, tx_exit;
    logic        wake_ev, wake_pull, host_pull, slow, power_ok, wr_en, rd_en;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    logic        oe_n, req_pad, woe_n, wake_pad, l1x, crst_n, train, cfg, flush;
    logic        ref_clk, req_wire_n, frst_n, wake_wire_n;
    logic [5:0]  obs;
    int          failures, total_checks, cycles;

    assign wake_wire_n = woe_n & ~wake_pull;
    assign obs = {flush, woe_n, cfg, crst_n, l1x, oe_n};

    lcr_host_model u_host (.req_oe_n_in(oe_n), .host_pull_in(host_pull), .slow_in(slow),
        .power_ok_in(power_ok), .ref_clock_out(ref_clk), .wire_n_out(req_wire_n),
        .fund_rst_n_out(frst_n));

    lcr_clock_request #(.CFG_READY_CYC(50), .L1_EXIT_BASE_NS(EXIT_BASE)) DUT (
        .clk_in(clk_in), .arst_n_in(arst_n), .fundamental_reset_n_in(frst_n),
        .ref_clock_in(ref_clk), .clock_request_n_in(req_wire_n),
        .clock_request_n_out(req_pad), .clock_request_oe_n_out(oe_n),
        .wake_request_n_in(wake_wire_n), .wake_request_n_out(wake_pad),
        .wake_request_oe_n_out(woe_n), .link_l1_idle_in(l1_idle), .l1_substate_in(subst),
        .link_l23_in(l23), .link_need_clk_in(need_clk), .rx_idle_exit_in(rx_exit),
        .tx_idle_exit_in(tx_exit), .wake_event_in(wake_ev), .l1_exit_request_out(l1x),
        .card_reset_n_out(crst_n), .train_enable_out(train), .config_ready_out(cfg),
        .flush_hint_out(flush), .addr_in(addr), .wdata_in(wdata), .wr_en_in(wr_en),
        .rd_en_in(rd_en), .rdata_out(rdata));

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    task close_out();
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Timeout ceiling covers two full power-up waits plus all scenarios.
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            failures++;
            close_out();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic await(input int sel, input logic v, input int n);
        int k;
        k = 0;
        while (obs[sel] !== v && k < n) begin
            @(negedge clk_in);
            k++;
        end
        chk(obs[sel], v);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in); addr <= a; wdata <= d; wr_en <= 1'b1;
        @(posedge clk_in); wr_en <= 1'b0;
    endtask

    // Read data stands one cycle only, then returns to zero.
    task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk_in); addr <= a; rd_en <= 1'b1;
        @(posedge clk_in); rd_en <= 1'b0;
        @(negedge clk_in); chk(rdata & m, e);
        @(negedge clk_in); chk(rdata, 32'h0);
    endtask

    task boot();
        @(posedge clk_in); power_ok <= 1'b1;
        @(negedge clk_in); chk(oe_n, 1'b0);
        chk({req_pad, wake_pad}, 2'h0);
        chk(flush, 1'b0);
        await(O_CRST, 1'b1, 21000);
        chk(train, 1'b0);
        @(negedge clk_in); chk(train, 1'b1);
        repeat (20) @(negedge clk_in);
        chk(cfg, 1'b0);
        await(O_CFG, 1'b1, 40);
    endtask

    task park();
        @(posedge clk_in); l1_idle <= 1'b1;
        await(O_REQ, 1'b1, 2);
    endtask

    task recover();
        @(posedge clk_in); l1_idle <= 1'b0; l23 <= 1'b0; subst <= 1'b0;
        await(O_EXIT, 1'b0, 250);
        repeat (4) @(negedge clk_in);
        chk(oe_n, 1'b0);
    endtask

    task t_regs();
        rchk(8'h0c, 32'h40000, 32'h40000);
        rchk(8'h10, 32'h100, 32'h100);
        rchk(8'h1c, 32'hffffffff, 32'(EXIT_BASE + lcr_pkg::ASSERT_TO_ACTIVE_NS));
        rchk(8'h40, 32'hffffffff, 32'h0);
        wr(8'h0c, 32'h0);
        rchk(8'h0c, 32'h40000, 32'h40000);
    endtask

    // Exit by transmit break, receive break and link need, clock running or parked.
    task t_exits();
        for (int i = 0; i < 3; i++) begin
            park();
            repeat (i * 30) @(negedge clk_in);
            chk(oe_n, 1'b1);
            @(posedge clk_in);
            tx_exit <= (i == 0); rx_exit <= (i == 1); need_clk <= (i == 2);
            @(posedge clk_in); {tx_exit, rx_exit, need_clk} <= 3'h0;
            @(negedge clk_in); chk({oe_n, l1x}, 2'h1);
            repeat (10) @(negedge clk_in);
            chk(l1x, 1'b1);
            recover();
        end
    endtask

    task t_late();
        rchk(8'h14, 32'h8, 32'h0);
        @(posedge clk_in); slow <= 1'b1;
        park();
        repeat (60) @(negedge clk_in);
        @(posedge clk_in); tx_exit <= 1'b1;
        @(posedge clk_in); tx_exit <= 1'b0;
        repeat (100) @(negedge clk_in);
        chk({oe_n, l1x}, 2'h1);
        rchk(8'h14, 32'h7, 32'h1);
        recover();
        rchk(8'h14, 32'h8, 32'h8);
        wr(8'h14, 32'h8);
        rchk(8'h14, 32'h8, 32'h0);
        @(posedge clk_in); slow <= 1'b0;
    endtask

    task t_host();
        park();
        repeat (8) @(negedge clk_in);
        rchk(8'h14, 32'h35, 32'h34);
        @(posedge clk_in); host_pull <= 1'b1;
        await(O_REQ, 1'b0, 8);
        chk(l1x, 1'b1);
        @(posedge clk_in); host_pull <= 1'b0;
        recover();
    endtask

    task t_wake();
        @(posedge clk_in); wake_ev <= 1'b1;
        @(posedge clk_in); wake_ev <= 1'b0;
        @(negedge clk_in); chk(woe_n, 1'b0);
        rchk(8'h18, 32'h1, 32'h1);
        wr(8'h18, 32'h1);
        await(O_WAKE, 1'b1, 2);
        repeat (4) begin
            @(negedge clk_in); chk(flush, 1'b0);
        end
        @(posedge clk_in); wake_pull <= 1'b1;
        await(O_FLUSH, 1'b1, 6);
        rchk(8'h18, 32'h2, 32'h2);
        @(posedge clk_in); wake_pull <= 1'b0;
        await(O_FLUSH, 1'b0, 6);
    endtask

    task t_pm();
        wr(8'h10, 32'h0);
        rchk(8'h10, 32'h100, 32'h0);
        @(posedge clk_in); l1_idle <= 1'b1;
        repeat (10) @(negedge clk_in);
        chk(oe_n, 1'b0);
        @(posedge clk_in); subst <= 1'b1;
        await(O_REQ, 1'b1, 2);
        recover();
        @(posedge clk_in); l23 <= 1'b1;
        await(O_REQ, 1'b1, 2);
        recover();
    endtask

    task t_warm();
        @(posedge clk_in); l23 <= 1'b1;
        await(O_REQ, 1'b1, 2);
        @(posedge clk_in); power_ok <= 1'b0;
        await(O_REQ, 1'b0, 6);
        await(O_CRST, 1'b0, 6);
        repeat (20) @(negedge clk_in);
        chk(oe_n, 1'b0);
        @(posedge clk_in); l23 <= 1'b0;
        boot();
        rchk(8'h10, 32'h100, 32'h100);
    endtask

    initial begin
        failures = 0;
        total_checks = 0;
        cycles = 0;
        arst_n = 1'b0;
        addr = 8'h0;
        wdata = 32'h0;
        {l1_idle, subst, l23, need_clk, rx_exit, tx_exit, wake_ev} = 7'h0;
        {wake_pull, host_pull, slow, power_ok, wr_en, rd_en} = 6'h0;
        repeat (15) @(posedge clk_in);
        @(negedge clk_in); chk({oe_n, woe_n, crst_n}, 3'h2);
        @(posedge clk_in); arst_n <= 1'b1;
        boot();
        t_regs();
        t_exits();
        t_late();
        t_host();
        t_wake();
        t_pm();
        t_warm();
        close_out();
    end
endmodule
`default_nettype wire
